// ==== rtl/otpb_pkg.sv ====
package otpb_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SEC_PROG = 8'h9b;
  localparam logic [7:0] OP_SEC_READ = 8'h77;
  localparam logic [7:0] OP_XFER_B1 = 8'h53;
  localparam logic [7:0] OP_XFER_B2 = 8'h55;
  localparam logic [7:0] OP_COMP_B1 = 8'h60;
  localparam logic [7:0] OP_COMP_B2 = 8'h61;
  localparam logic [7:0] OP_RFSH_B1 = 8'h58;
  localparam logic [7:0] OP_RFSH_B2 = 8'h59;

  // ----------------------------------------------------------------
  // Security area layout
  // ----------------------------------------------------------------
  localparam int SEC_BYTES = 128;
  localparam int USER_BYTES = 64;
  localparam int USER_AW = 6;
  localparam int HDR_BITS = 32;

  // ----------------------------------------------------------------
  // Page index field positions in the address word
  // ----------------------------------------------------------------
  localparam int PIDX_W = 12;
  localparam int PIDX_STD_LSB = 10;
  localparam int PIDX_BIN_LSB = 9;

  // ----------------------------------------------------------------
  // Timing, clock rate and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int PAGE_TRANSFER_TIME_US = 200;
  localparam int PAGE_COMPARE_TIME_US = 200;
  localparam int PAGE_REFRESH_TIME_US = 25000;
  localparam int OTP_PROGRAM_TIME_US = 4000;
  localparam int XFER_CYC = PAGE_TRANSFER_TIME_US * (CLK_HZ / 1000000);
  localparam int COMP_CYC = PAGE_COMPARE_TIME_US * (CLK_HZ / 1000000);
  localparam int RFSH_CYC = PAGE_REFRESH_TIME_US * (CLK_HZ / 1000000);
  localparam int OTPP_CYC = OTP_PROGRAM_TIME_US * (CLK_HZ / 1000000);
  localparam int TMR_W = 24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RDY_RST = 1'b1;
  localparam logic COMP_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_XFER = 5'b00010,
    ST_COMP = 5'b00100,
    ST_RFSH = 5'b01000,
    ST_OTP  = 5'b10000
  } otpb_state_e;

  typedef enum logic [1:0] {
    ARR_XFER = 2'h0,
    ARR_COMP = 2'h1,
    ARR_RFSH = 2'h2
  } otpb_arr_op_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic full;
  } otpb_frame_s;

  typedef struct packed {
    otpb_arr_op_e op;
    logic [PIDX_W-1:0] page;
    logic buf_sel;
  } otpb_arr_s;

endpackage

// ==== rtl/otpb_dpram.sv ====
`timescale 1ns/10ps
// Two-clock memory: write on wclk, registered read on rclk.
module otpb_dpram #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  input wire logic wclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic rclk,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port.
  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data leave through a register.
  always_ff @(posedge rclk) begin
    rdata <= mem[raddr];
  end

endmodule

// ==== rtl/otpb_core.sv ====
`timescale 1ns/10ps
// Operation
// - 128-byte area, user half, fixed unique half.
// - User half programs only once.
// - User half programs without prior erase.
// - Chip select rise starts timed program, busy.
// - Unsupplied user bytes are not guaranteed.
// - Beyond 64 bytes pointer wraps to zero.
// - First buffer holds programming data.
// - 77h plus dummies reads area from byte 0.
// - Past last byte output is undefined.
// - Chip select rise ends read, output released.
// - 53h/55h copy page into buffer.
// - Page index position depends on page size.
// - Copy starts at select rise, busy meanwhile.
// - 60h/61h compare page with buffer.
// - Compare busy, result into status bit.
// - Result zero on match, one on mismatch.
// - 58h/59h refresh page through buffer.
// - Refresh copies then reprograms, busy meanwhile.
// - Ready flag low busy, high ready.
// - Page-size bit selects address format.
module otpb_core
#(
  parameter int RFSH_CYCLES = otpb_pkg::RFSH_CYC,
  parameter int OTPP_CYCLES = otpb_pkg::OTPP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  input wire logic page_binary,
  input wire logic arr_done_mismatch,
  output logic ready,
  output logic compare_diff,
  output logic page_size_bit,
  output logic arr_req,
  output otpb_pkg::otpb_arr_s arr_cmd,
  output logic buf1_busy
);
  import otpb_pkg::*;

  // ----------------------------------------------------------------
  // Serial clock domain: header shifter and byte counting
  // ----------------------------------------------------------------
  logic spi_clr;
  logic [15:0] bit_cnt_reg, bit_cnt_next;
  logic [31:0] hdr_reg, hdr_next;
  otpb_frame_s frame_reg, frame_next;
  logic [6:0] rd_idx_reg, rd_idx_next;
  logic [15:0] nxt_byte;
  logic stg_we;
  logic [USER_AW-1:0] stg_waddr;
  logic [7:0] stg_wdata;
  logic [7:0] otp_rdata;
  logic hdr_tgl_reg, hdr_tgl_next, hdr_seen_reg, hdr_seen_next;

  assign spi_clr = rst | cs_n;
  assign nxt_byte = (bit_cnt_reg + 16'h0001) >> 3;

  // Next values for the serial-clock rising edge.
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    if (bit_cnt_reg != 16'hffff) begin
      bit_cnt_next = bit_cnt_reg + 16'h0001;
    end
    hdr_next = {hdr_reg[30:0], si};
    frame_next = frame_reg;
    if (bit_cnt_reg == 16'h0000) begin
      frame_next.full = 1'b0;
    end
    if (bit_cnt_reg == 16'(HDR_BITS - 1)) begin
      frame_next = '{opcode: hdr_next[31:24], addr: hdr_next[23:0],
                     full: 1'b1};
    end
    // Address of the byte shifted out next, read a byte ahead.
    rd_idx_next = 7'(nxt_byte - 16'h0004);
    hdr_tgl_next = hdr_tgl_reg ^ (bit_cnt_reg == 16'(HDR_BITS - 1));
  end

  // Header counters restart with every frame.
  always_ff @(posedge sck or posedge spi_clr) begin
    if (spi_clr) begin
      bit_cnt_reg <= 16'h0000;
      hdr_reg <= 32'h0000_0000;
      rd_idx_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      hdr_reg <= hdr_next;
      rd_idx_reg <= rd_idx_next;
    end
  end

  // The decoded header outlives the frame so the core can act on it.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      frame_reg <= '0;
      hdr_tgl_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      hdr_tgl_reg <= hdr_tgl_next;
    end
  end

  // ----------------------------------------------------------------
  // Program data capture into the first buffer stand-in
  // ----------------------------------------------------------------
  // Every whole data byte lands in the staging buffer, pointer wraps.
  assign stg_we = frame_reg.full && frame_reg.opcode == OP_SEC_PROG
                  && bit_cnt_reg >= 16'(HDR_BITS)
                  && bit_cnt_reg[2:0] == 3'h7;
  assign stg_waddr = USER_AW'((bit_cnt_reg >> 3) - 16'h0004);
  assign stg_wdata = {hdr_reg[6:0], si};

  // ----------------------------------------------------------------
  // Read-out path, shifted on the falling serial clock edge
  // ----------------------------------------------------------------
  logic [7:0] out_sh_reg, out_sh_next;
  logic oe_reg, oe_next;
  logic [7:0] rd_byte;
  logic rd_active;

  // Unique half is a fixed per-device constant; values are arbitrary.
  function automatic logic [7:0] factory_byte(input logic [6:0] idx);
    factory_byte = {1'b1, idx} ^ 8'h5a;
  endfunction

  // Indices past the end wrap and read the area again from byte 0.
  assign rd_byte = (rd_idx_reg < 7'(USER_BYTES)) ? otp_rdata
                   : factory_byte(rd_idx_reg);
  assign rd_active = frame_reg.full && frame_reg.opcode == OP_SEC_READ
                     && bit_cnt_reg >= 16'(HDR_BITS);

  // Next values for the output shifter.
  always_comb begin
    out_sh_next = {out_sh_reg[6:0], 1'b0};
    oe_next = rd_active;
    if (rd_active && bit_cnt_reg[2:0] == 3'h0) begin
      out_sh_next = rd_byte;
    end
  end

  // Chip select high clears the driver at once.
  always_ff @(negedge sck or posedge spi_clr) begin
    if (spi_clr) begin
      out_sh_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      out_sh_reg <= out_sh_next;
      oe_reg <= oe_next;
    end
  end

  assign so_o = out_sh_reg[7];
  assign so_oe = oe_reg & ~cs_n;

  // ----------------------------------------------------------------
  // Chip select crossing into the core clock
  // ----------------------------------------------------------------
  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic cs_rise;

  // Two-stage synchroniser plus a delayed copy for edge detect.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg <= cs_s2_reg;
    end
  end

  // The frame record is static while select stays high.
  assign cs_rise = cs_s2_reg & ~cs_d_reg;

  // ----------------------------------------------------------------
  // Self-timed operation sequencer
  // ----------------------------------------------------------------
  otpb_state_e st_reg, st_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [6:0] cp_reg, cp_next;
  logic comp_reg, comp_next;
  logic otp_used_reg, otp_used_next;
  logic req_reg, req_next;
  otpb_arr_s cmd_reg, cmd_next;
  logic [PIDX_W-1:0] pidx;
  logic hdr_ok;
  logic otp_we;
  logic [7:0] stg_rdata;

  // Page index lives at a layout chosen by the page-size setting.
  assign pidx = page_binary
    ? frame_reg.addr[PIDX_BIN_LSB +: PIDX_W]
    : frame_reg.addr[PIDX_STD_LSB +: PIDX_W];
  assign hdr_ok = frame_reg.full && hdr_tgl_reg != hdr_seen_reg;

  // Next values for the sequencer; busy commands are ignored.
  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg;
    cp_next = cp_reg;
    comp_next = comp_reg;
    otp_used_next = otp_used_reg;
    hdr_seen_next = cs_rise ? hdr_tgl_reg : hdr_seen_reg; // Used once.
    req_next = 1'b0;
    cmd_next = cmd_reg;
    case (st_reg)
      ST_IDLE: begin
        if (cs_rise && hdr_ok) begin
          cmd_next.page = pidx;
          case (frame_reg.opcode)
            OP_XFER_B1, OP_XFER_B2: begin
              st_next = ST_XFER;
              tmr_next = TMR_W'(XFER_CYC);
              cmd_next.op = ARR_XFER;
              cmd_next.buf_sel = frame_reg.opcode[2];
              req_next = 1'b1;
            end
            OP_COMP_B1, OP_COMP_B2: begin
              st_next = ST_COMP;
              tmr_next = TMR_W'(COMP_CYC);
              cmd_next.op = ARR_COMP;
              cmd_next.buf_sel = frame_reg.opcode[0];
              req_next = 1'b1;
            end
            OP_RFSH_B1, OP_RFSH_B2: begin
              st_next = ST_RFSH;
              tmr_next = TMR_W'(RFSH_CYCLES);
              cmd_next.op = ARR_RFSH;
              cmd_next.buf_sel = frame_reg.opcode[0];
              req_next = 1'b1;
            end
            OP_SEC_PROG: begin
              if (frame_reg.addr == 24'h000000 && !otp_used_reg) begin
                st_next = ST_OTP;
                tmr_next = TMR_W'(OTPP_CYCLES);
                cp_next = 7'h00;
                otp_used_next = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_XFER, ST_RFSH: begin
        tmr_next = tmr_reg - 1'b1;
        if (tmr_reg <= TMR_W'(1)) begin
          st_next = ST_IDLE;
        end
      end
      ST_COMP: begin
        tmr_next = tmr_reg - 1'b1;
        if (tmr_reg <= TMR_W'(1)) begin
          comp_next = arr_done_mismatch;
          st_next = ST_IDLE;
        end
      end
      ST_OTP: begin
        tmr_next = tmr_reg - 1'b1;
        if (cp_reg <= 7'(USER_BYTES)) begin
          cp_next = cp_reg + 7'h01;
        end
        if (tmr_reg <= TMR_W'(1)) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      tmr_reg <= '0;
      cp_reg <= 7'h00;
      comp_reg <= COMP_RST;
      otp_used_reg <= 1'b0;
      hdr_seen_reg <= 1'b0;
      req_reg <= 1'b0;
      cmd_reg <= '0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      cp_reg <= cp_next;
      comp_reg <= comp_next;
      otp_used_reg <= otp_used_next;
      hdr_seen_reg <= hdr_seen_next;
      req_reg <= req_next;
      cmd_reg <= cmd_next;
    end
  end

  // Direct copy of the staged bytes into the user half, no erase step.
  assign otp_we = st_reg == ST_OTP && cp_reg >= 7'h01
                  && cp_reg <= 7'(USER_BYTES);

  assign ready = (st_reg == ST_IDLE);
  assign compare_diff = comp_reg;
  assign page_size_bit = page_binary;
  assign arr_req = req_reg;
  assign arr_cmd = cmd_reg;
  assign buf1_busy = (st_reg == ST_OTP);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  otpb_dpram #(.DW(8), .AW(USER_AW)) u_stage (
    .wclk(sck),
    .we(stg_we),
    .waddr(stg_waddr),
    .wdata(stg_wdata),
    .rclk(clk),
    .raddr(cp_reg[USER_AW-1:0]),
    .rdata(stg_rdata)
  );

  otpb_dpram #(.DW(8), .AW(USER_AW)) u_user (
    .wclk(clk),
    .we(otp_we),
    .waddr(USER_AW'(cp_reg - 7'h01)),
    .wdata(stg_rdata),
    .rclk(sck),
    .raddr(rd_idx_next[USER_AW-1:0]),
    .rdata(otp_rdata)
  );

endmodule

// ==== sim/otpb_core_assertions.sv ====
`timescale 1ns/10ps
module otpb_core_assertions
#(
  parameter int RFSH_CYCLES = 200,
  parameter int OTPP_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic page_binary,
  input wire logic ready,
  input wire logic compare_diff,
  input wire logic page_size_bit,
  input wire logic arr_req,
  input wire otpb_pkg::otpb_arr_s arr_cmd,
  input wire logic buf1_busy
);
  import otpb_pkg::*;
  localparam int M1 = RFSH_CYCLES > OTPP_CYCLES ? RFSH_CYCLES : OTPP_CYCLES;
  localparam int BUSY_MAX = (M1 > XFER_CYC ? M1 : XFER_CYC) + 2;
  logic [23:0] busy_reg;
  logic [23:0] busy_next;
  // Counts the cycles that the ready flag has stayed low.
  always_comb begin
    busy_next = ready ? 24'h0 : busy_reg + 24'h1;
  end
  // Registers the busy counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 24'h0;
    end else begin
      busy_reg <= busy_next;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A compare launched towards the array.
  sequence s_cmp_start;
    arr_req && arr_cmd.op == ARR_COMP;
  endsequence
  a_oe_release: assert property (cs_n |-> !so_oe)
    else $error("output enabled while deselected");
  a_busy_bound: assert property (busy_reg <= BUSY_MAX)
    else $error("busy longer than any operation");
  a_req_pulse: assert property (arr_req |=> !arr_req)
    else $error("array request longer than one cycle");
  a_req_busy: assert property (arr_req |-> ##[0:1] !ready)
    else $error("array request without busy");
  a_page_size: assert property ($stable(page_binary)
    |-> page_size_bit == page_binary)
    else $error("page size bit differs from setting");
  a_comp_hold: assert property ($changed(compare_diff)
    |-> !$past(ready) || !$past(ready, 2))
    else $error("compare bit changed outside a compare end");
  a_busy_min: assert property ($fell(ready) |-> !ready [*8])
    else $error("busy flag glitched");
  a_cmp_busy: assert property (s_cmp_start |-> ##1 !ready [*8])
    else $error("compare not busy");
  a_otp_busy: assert property ($rose(buf1_busy) |-> ##[0:2] !ready)
    else $error("security program not busy");
endmodule

bind otpb_core otpb_core_assertions #(
  .RFSH_CYCLES(RFSH_CYCLES),
  .OTPP_CYCLES(OTPP_CYCLES)
) otpb_core_assertions_i (
  .clk(clk),
  .rst(rst),
  .cs_n(cs_n),
  .so_oe(so_oe),
  .page_binary(page_binary),
  .ready(ready),
  .compare_diff(compare_diff),
  .page_size_bit(page_size_bit),
  .arr_req(arr_req),
  .arr_cmd(arr_cmd),
  .buf1_busy(buf1_busy)
);

// ==== sim/otpb_spi_host.sv ====
`timescale 1ns/10ps
module otpb_spi_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // The serial clock stands low and select high between frames.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Opens a frame after a gap that lets the last one settle.
  task automatic start();
    #250 cs_n = 1'b0;
    #20;
  endtask
  // Shifts one byte in, most significant bit first, mode 0.
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      si = b[i];
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
  endtask
  // Samples one byte of output on rising serial clock edges.
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #15 sck = 1'b1;
      b[i] = so;
      #15 sck = 1'b0;
    end
  endtask
  // Closes the frame; the data line no longer holds valid data.
  task automatic stop();
    #20 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ==== sim/test_otp_and_page_buffer_commands.sv ====
`timescale 1ns/10ps
module test_otp_and_page_buffer_commands;
  import otpb_pkg::*;
  localparam int RFSH_N = 200;
  localparam int OTPP_N = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic page_binary = 1'b0;
  logic arr_done_mismatch = 1'b0;
  logic sck, cs_n, si, so_o, so_oe, ready, compare_diff;
  logic page_size_bit, arr_req, buf1_busy;
  logic exp_diff = 1'b0;
  otpb_arr_s arr_cmd;
  wire so_w = so_oe ? so_o : 1'bz;
  int mismatches = 0;
  int checks = 0;
  otpb_core #(.RFSH_CYCLES(RFSH_N), .OTPP_CYCLES(OTPP_N)) otpb_core_i (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
    .so_oe(so_oe), .page_binary(page_binary),
    .arr_done_mismatch(arr_done_mismatch), .ready(ready),
    .compare_diff(compare_diff), .page_size_bit(page_size_bit),
    .arr_req(arr_req), .arr_cmd(arr_cmd), .buf1_busy(buf1_busy));
  otpb_spi_host otpb_spi_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so_w));
  // Core clock.
  always #25 clk = ~clk;
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Waits for ready under a bound and returns the cycles spent.
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Sends one array command and judges request, busy time and result.
  task automatic arr_op(input logic [7:0] op, input logic [11:0] pg,
    input logic bin, input logic mism, input logic [1:0] eop,
    input logic sel, input int cyc);
    logic [23:0] a;
    int n;
    @(posedge clk);
    page_binary <= bin;
    arr_done_mismatch <= mism;
    a = bin ? {3'h5, pg, 9'h1ab} : {2'h2, pg, 10'h2cd};
    otpb_spi_host_i.start();
    otpb_spi_host_i.put(op);
    otpb_spi_host_i.put(a[23:16]);
    otpb_spi_host_i.put(a[15:8]);
    otpb_spi_host_i.put(a[7:0]);
    otpb_spi_host_i.stop();
    n = 0;
    while (arr_req !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(arr_req, 1'b1);
    check(32'(arr_cmd), 32'({eop, pg, sel}));
    check(page_size_bit, bin);
    @(posedge clk);
    #1;
    check(ready, 1'b0);
    wait_ready(n);
    check(n >= cyc - 3 && n <= cyc + 1, 1'b1);
    if (eop == ARR_COMP) exp_diff = mism;
    check(compare_diff, exp_diff);
  endtask
  // Reads the whole security area and compares every byte.
  task automatic otp_read(input logic [7:0] first);
    logic [7:0] b;
    otpb_spi_host_i.start();
    otpb_spi_host_i.put(OP_SEC_READ);
    repeat (3) otpb_spi_host_i.put(8'h00);
    for (int i = 0; i < 128; i++) begin
      otpb_spi_host_i.get(b);
      if (i == 0) check(b, first);
      else if (i < 64) check(b, 8'(i) ^ 8'h3c);
      else check(b, {1'b1, 7'(i)} ^ 8'h5a);
    end
    otpb_spi_host_i.stop();
    @(posedge clk);
    #1;
    check(so_oe, 1'b0);
  endtask
  // Programs the user half with a wrapping stream, then tries again.
  task automatic scen_otp();
    int n;
    otpb_spi_host_i.start();
    otpb_spi_host_i.put(OP_SEC_PROG);
    repeat (3) otpb_spi_host_i.put(8'h00);
    for (int i = 0; i < 65; i++) begin
      otpb_spi_host_i.put(8'(i) ^ 8'h3c);
    end
    otpb_spi_host_i.stop();
    repeat (6) @(posedge clk);
    #1;
    check(buf1_busy, 1'b1);
    check(ready, 1'b0);
    wait_ready(n);
    check(n >= OTPP_N - 6 && n <= OTPP_N + 1, 1'b1);
    otp_read(8'h7c);
    otpb_spi_host_i.start();
    otpb_spi_host_i.put(OP_SEC_PROG);
    repeat (4) otpb_spi_host_i.put(8'h00);
    otpb_spi_host_i.stop();
    repeat (8) @(posedge clk);
    #1;
    check(ready, 1'b1);
    otp_read(8'h7c);
  endtask
  // Copies a page into each buffer, one per page layout.
  task automatic scen_xfer();
    arr_op(OP_XFER_B1, 12'h000, 1'b0, 1'b0, ARR_XFER, 1'b0, XFER_CYC);
    arr_op(OP_XFER_B2, 12'hfff, 1'b1, 1'b0, ARR_XFER, 1'b1, XFER_CYC);
  endtask
  // Compares pages with both buffers, a mismatch and then a match.
  task automatic scen_comp();
    arr_op(OP_COMP_B1, 12'ha5c, 1'b0, 1'b1, ARR_COMP, 1'b0, COMP_CYC);
    arr_op(OP_COMP_B2, 12'h3a1, 1'b1, 1'b0, ARR_COMP, 1'b1, COMP_CYC);
  endtask
  // Refreshes pages through both buffers; the compare bit must hold.
  task automatic scen_rfsh();
    arr_op(OP_RFSH_B1, 12'h801, 1'b1, 1'b1, ARR_RFSH, 1'b0, RFSH_N);
    arr_op(OP_RFSH_B2, 12'h07e, 1'b0, 1'b0, ARR_RFSH, 1'b1, RFSH_N);
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(ready, RDY_RST);
    check(compare_diff, COMP_RST);
    check(so_oe, 1'b0);
    scen_xfer();
    scen_comp();
    scen_rfsh();
    scen_otp();
    report_and_stop();
  end
  // Cuts a hung run short.
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule
